// file: bench/cgr_host.sv
// Host model on the register strobe port
`default_nettype none
module cgr_host(input wire logic clk_sys, output logic wr, rd, output logic [5:0] a,
    output logic [15:0] d);
timeunit 1ns; timeprecision 1ns;
initial {wr, rd, a, d} = '0;
// One strobe per access, dropped at the next edge
task acc(input logic w, input logic [5:0] ad, input logic [15:0] dt);
    @(posedge clk_sys) {wr, rd, a, d} <= {w, !w, ad, dt};
    @(posedge clk_sys) {wr, rd} <= 2'b00;
endtask
endmodule
`default_nettype wire

// file: bench/cgr_regs_sva.sv
// Checker for the gain register bank
`default_nettype none
module cgr_regs_sva(input wire logic clk_sys, rst, reg_wr, reg_rd,
    input wire logic [5:0] reg_addr, input wire logic [15:0] reg_wdata, reg_rdata_q,
    input wire logic [23:0] chan1_gain_q, input wire logic checksum_load);
default clocking @(posedge clk_sys); endclocking
default disable iff (rst);
a_gain_reset: assert property ($fell(rst) |-> chan1_gain_q == 24'h800000)
    else $error("gain reset");
a_upper_load: assert property (reg_wr && reg_addr == 6'h11 |=>
    ##1 chan1_gain_q[23:8] == $past(reg_wdata, 2)) else $error("upper gain");
a_lower_read: assert property (reg_rd && reg_addr == 6'h12 |=>
    reg_rdata_q[7:0] == 8'h00) else $error("low byte");
a_lower_load: assert property (reg_wr && reg_addr == 6'h12 |=>
    ##1 chan1_gain_q[7:0] == $past(reg_wdata[15:8], 2)) else $error("lower gain");
a_upper_read: assert property (reg_rd && reg_addr == 6'h11 && !$past(reg_wr) |=>
    reg_rdata_q == $past(chan1_gain_q[23:8])) else $error("upper read");
a_sum_ro: assert property ((reg_rd && reg_addr == 6'h3e && !checksum_load)
    ##1 (!checksum_load)[*3] ##1 (reg_rd && reg_addr == 6'h3e)
    |=> reg_rdata_q == $past(reg_rdata_q, 4)) else $error("checksum moved");
c_rd_sum: cover property (reg_rd && reg_addr == 6'h3e);
c_wr_up: cover property (reg_wr && reg_addr == 6'h11);
c_wr_lo: cover property (reg_wr && reg_addr == 6'h12);
endmodule
bind cgr_regs cgr_regs_sva u_sva(.clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata_q, .chan1_gain_q, .checksum_load);
`default_nettype wire

// file: bench/ch1_gain_cal_and_map_crc_regs_tb_top.sv
// Bench for the gain and checksum register bank
`default_nettype none
module ch1_gain_cal_and_map_crc_regs_tb_top;
timeunit 1ns; timeprecision 1ns;
logic clk_sys = 0, rst = 1, cl = 0, wr, rd, rv; logic [5:0] a; logic [15:0] d, q;
logic [23:0] g; int failures = 0, checks_done = 0, cyc = 0;
cgr_host H(.clk_sys, .wr, .rd, .a, .d);
cgr_regs DUT(.clk_sys, .rst, .reg_wr(wr), .reg_rd(rd), .reg_addr(a), .reg_wdata(d),
    .checksum_in(16'h5a5a), .checksum_load(cl), .reg_rdata_q(q), .reg_rvalid_q(rv),
    .chan1_gain_q(g));
initial forever #10 clk_sys = ~clk_sys;
always @(posedge clk_sys) if (++cyc > 500) begin failures++; stop_test; end
task chk(input logic [23:0] x, e); checks_done++;
    if (x !== e) begin failures++; $display("ERROR %0t %h %h", $time, x, e); end
endtask
// Read data stands one cycle, so it is judged just after that edge
task rdc(input logic [5:0] ad, input logic [15:0] e); H.acc(0, ad, 0);
    #1 chk({7'h00, rv, q}, {8'h01, e}); endtask
task t_reset; rdc(6'h11, 16'h8000); chk(g, 24'h800000);
    rdc(6'h12, 16'h0000); rdc(6'h3e, 16'h0000); endtask
task t_gain; H.acc(1, 6'h11, 16'hfedc); H.acc(1, 6'h12, 16'hba98);
    rdc(6'h12, 16'hba00); rdc(6'h11, 16'hfedc);
    chk(g, 24'hfedcba); endtask
task t_ro; @(posedge clk_sys) cl <= 1; @(posedge clk_sys) cl <= 0;
    H.acc(1, 6'h3e, 16'h1111); rdc(6'h3e, 16'h5a5a);
    H.acc(1, 6'h3f, 16'h0000); rdc(6'h3f, 16'h0000); endtask
task stop_test; $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish; endtask
initial begin repeat (16) @(posedge clk_sys); rst <= 0; t_reset; t_gain; t_ro; stop_test; end
endmodule
`default_nettype wire

// file: rtl/cgr_defs.vh
// Register offsets, reset values and field positions for the gain and checksum bank
`ifndef CGR_DEFS_VH
`define CGR_DEFS_VH
`define CGR_ADDR_GAIN_UPPER   6'h11
`define CGR_ADDR_GAIN_LOWER   6'h12
`define CGR_ADDR_CHECKSUM     6'h3e
`define CGR_ADDR_SPARE        6'h3f
`define CGR_RST_GAIN_UPPER    16'h8000
`define CGR_RST_GAIN_LOWER    16'h0000
`define CGR_RST_CHECKSUM      16'h0000
`define CGR_RST_SPARE         16'h0000
`define CGR_LOWER_FIELD_HI    15
`define CGR_LOWER_FIELD_LO    8
`define CGR_RST_GAIN_LOW_FIELD 8'h00
`define CGR_LOWER_RSVD_BYTE   8'h00
`define CGR_RST_GAIN_COEF     24'h800000
`define CGR_RST_RDATA         16'h0000
`endif

// file: rtl/cgr_regs.v
// Channel 1 gain calibration pair, map checksum and spare word register bank
//
// Summary of operation
// RULE_01 - The upper gain register sits at 11h and resets to 8000h for unity gain.
// RULE_02 - All sixteen upper gain bits are read/write and form coefficient bits 23 to 8.
// RULE_03 - The lower gain register sits at 12h, resets to 0000h, and its low byte reads zero.
// RULE_04 - Lower gain bits 15 to 8 are read/write and form coefficient bits 7 to 0.
// RULE_05 - The read-only map checksum sits at 3Eh and reads 0000h after reset.
// RULE_06 - The host writes only zero to the spare word at 3Fh, which resets to zero and is read/write.
// RULE_07 - Writes to the checksum and the reserved low byte of the lower gain register are ignored.
//
// One access per strobe; read data and its valid flag follow one cycle later
// The two gain writes are not atomic, so the coefficient is mixed in between

`include "cgr_defs.vh"

`default_nettype none

module cgr_regs #(
    parameter AW = 6
) (
    input  wire          clk_sys,
    input  wire          rst,
    input  wire          reg_wr,
    input  wire          reg_rd,
    input  wire [AW-1:0] reg_addr,
    input  wire [15:0]   reg_wdata,
    input  wire [15:0]   checksum_in,
    input  wire          checksum_load,
    output reg  [15:0]   reg_rdata_q,
    output reg           reg_rvalid_q,
    output reg  [23:0]   chan1_gain_q
);

    // Word, field and coefficient widths
    localparam DW = 16;
    localparam FW = 8;
    localparam GW = 24;

    // Address decode shared by all selects
    function addr_hit;
        input [AW-1:0] addr;
        input [AW-1:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    // Decoded selects, write enables and read views
    wire          sel_upper;
    wire          sel_lower;
    wire          sel_checksum;
    wire          sel_spare;
    wire          wr_upper;
    wire          wr_lower;
    wire          wr_spare;
    wire [FW-1:0] low_field_wdata;
    wire [DW-1:0] upper_view;
    wire [DW-1:0] lower_view;
    wire [DW-1:0] checksum_view;
    wire [DW-1:0] spare_view;

    // Storage and next values
    reg  [DW-1:0] chan1_gain_upper_q;
    reg  [DW-1:0] chan1_gain_upper_d;
    reg  [FW-1:0] chan1_gain_low_field_q;
    reg  [FW-1:0] chan1_gain_low_field_d;
    reg  [DW-1:0] map_checksum_q;
    reg  [DW-1:0] map_checksum_d;
    reg  [DW-1:0] spare_word_q;
    reg  [DW-1:0] spare_word_d;
    reg  [DW-1:0] read_mux;
    reg  [DW-1:0] reg_rdata_d;
    reg           reg_rvalid_d;
    reg  [GW-1:0] chan1_gain_d;

    assign sel_upper    = addr_hit(reg_addr, `CGR_ADDR_GAIN_UPPER);
    assign sel_lower    = addr_hit(reg_addr, `CGR_ADDR_GAIN_LOWER);
    assign sel_checksum = addr_hit(reg_addr, `CGR_ADDR_CHECKSUM);
    assign sel_spare    = addr_hit(reg_addr, `CGR_ADDR_SPARE);

    // No write enable exists for the checksum, so bus writes to it fall away
    assign wr_upper = reg_wr & sel_upper;
    assign wr_lower = reg_wr & sel_lower;
    assign wr_spare = reg_wr & sel_spare;

    // Reserved low byte of the lower word is never stored
    assign low_field_wdata = reg_wdata[`CGR_LOWER_FIELD_HI:`CGR_LOWER_FIELD_LO]; // RULE_04

    // Upper gain word, all sixteen bits writable
    always @* begin
        chan1_gain_upper_d = chan1_gain_upper_q;
        if (wr_upper) begin
            chan1_gain_upper_d = reg_wdata; // RULE_02
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            chan1_gain_upper_q <= `CGR_RST_GAIN_UPPER; // RULE_01
        end else begin
            chan1_gain_upper_q <= chan1_gain_upper_d;
        end
    end

    // Lower gain field, high byte only
    always @* begin
        chan1_gain_low_field_d = chan1_gain_low_field_q;
        if (wr_lower) begin
            chan1_gain_low_field_d = low_field_wdata; // RULE_04
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            chan1_gain_low_field_q <= `CGR_RST_GAIN_LOW_FIELD; // RULE_03
        end else begin
            chan1_gain_low_field_q <= chan1_gain_low_field_d;
        end
    end

    // Checksum only moves from the internal engine, never from a bus write
    always @* begin
        map_checksum_d = map_checksum_q; // RULE_07
        if (checksum_load) begin
            map_checksum_d = checksum_in;
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            map_checksum_q <= `CGR_RST_CHECKSUM; // RULE_05
        end else begin
            map_checksum_q <= map_checksum_d;
        end
    end

    // Spare word stores whatever is written; keeping it zero is up to the host
    always @* begin
        spare_word_d = spare_word_q;
        if (wr_spare) begin
            spare_word_d = reg_wdata; // RULE_06
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            spare_word_q <= `CGR_RST_SPARE; // RULE_06
        end else begin
            spare_word_q <= spare_word_d;
        end
    end

    // Read views; the reserved byte is forced to zero, never taken from storage
    assign upper_view    = chan1_gain_upper_q;
    assign lower_view    = {chan1_gain_low_field_q, `CGR_LOWER_RSVD_BYTE}; // RULE_03
    assign checksum_view = map_checksum_q; // RULE_05
    assign spare_view    = spare_word_q;

    // Unmapped addresses read as zero
    always @* begin
        case (1'b1)
            sel_upper:    read_mux = upper_view;
            sel_lower:    read_mux = lower_view;
            sel_checksum: read_mux = checksum_view;
            sel_spare:    read_mux = spare_view;
            default:      read_mux = `CGR_RST_RDATA;
        endcase
    end

    always @* begin
        reg_rvalid_d = reg_rd;
    end

    // Read data drops back to zero when no read is made
    always @* begin
        reg_rdata_d = `CGR_RST_RDATA;
        if (reg_rd) begin
            reg_rdata_d = read_mux;
        end
    end

    // Coefficient lags the register writes by one cycle
    always @* begin
        chan1_gain_d = {chan1_gain_upper_q, chan1_gain_low_field_q}; // RULE_02
    end

    // Registered read data keeps outputs glitch free; costs one cycle of latency
    always @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata_q <= `CGR_RST_RDATA;
        end else begin
            reg_rdata_q <= reg_rdata_d;
        end
    end

    // Valid marks the one cycle in which read data stands
    always @(posedge clk_sys) begin
        if (rst) begin
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_rvalid_d;
        end
    end

    // Coefficient output held at unity scale through reset
    always @(posedge clk_sys) begin
        if (rst) begin
            chan1_gain_q <= `CGR_RST_GAIN_COEF; // RULE_01
        end else begin
            chan1_gain_q <= chan1_gain_d;
        end
    end

endmodule
`default_nettype wire
